//--- rtl/accl_pkg.sv
/*
 comparator control logic: register map, field positions, reset values, codes.
 assumes one 100 MHz system clock and avalon-mm word-aligned byte addresses.
*/
package accl_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ACCL_OFS_CTRL_STATUS = 8'h08;
    localparam logic [7:0] ACCL_OFS_PAIR_SELECT = 8'h0C;
    localparam logic [7:0] ACCL_OFS_IRQ_STATUS  = 8'h10;
    localparam logic [7:0] ACCL_OFS_IRQ_MASK    = 8'h14;

    // ----------------------------------------------------------------
    // control/status field positions
    // ----------------------------------------------------------------
    localparam int ACCL_BIT_POWER_OFF = 7;
    localparam int ACCL_BIT_BANDGAP   = 6;
    localparam int ACCL_BIT_RESULT    = 5;
    localparam int ACCL_BIT_FLAG      = 4;
    localparam int ACCL_BIT_IRQ_EN    = 3;
    localparam int ACCL_BIT_BORROW    = 2;
    localparam int ACCL_BIT_MODE_HI   = 1;
    localparam int ACCL_BIT_MODE_LO   = 0;

    // irq status/mask bits
    localparam int ACCL_IRQ_TRIGGER   = 0;
    localparam int ACCL_IRQ_CHANGE    = 1;
    localparam int ACCL_IRQ_BITS      = 2;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic       ACCL_RST_BIT      = 1'b0;
    localparam logic [1:0] ACCL_RST_MODE     = 2'h0;
    localparam logic [2:0] ACCL_RST_PAIR     = 3'h0;
    localparam logic [1:0] ACCL_RST_IRQ      = 2'h0;
    localparam logic       ACCL_RST_WAIT     = 1'b1;

    // ----------------------------------------------------------------
    // trigger modes and input codes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ACCL_MODE_TOGGLE   = 2'b00,
        ACCL_MODE_RESERVED = 2'b01,
        ACCL_MODE_FALL     = 2'b10,
        ACCL_MODE_RISE     = 2'b11
    } accl_mode_t;

    localparam logic [1:0] ACCL_POS_PIN0    = 2'h0;
    localparam logic [1:0] ACCL_POS_PIN1    = 2'h1;
    localparam logic [1:0] ACCL_POS_PIN2    = 2'h2;
    localparam logic [1:0] ACCL_POS_BANDGAP = 2'h3;

    localparam int         ACCL_NUM_CHAN    = 11;
    localparam logic [5:0] ACCL_LAST_CHAN   = 6'h0A;
    localparam int         ACCL_BANDGAP_MV  = 1100;
    localparam int         ACCL_SYNC_STAGES = 2;
endpackage : accl_pkg

//--- rtl/accl_top.sv
/*
 comparator control logic: input selection, result compare and synchroniser,
 trigger detection, event flag, interrupt request and avalon-mm registers.
 assumes pin levels arrive as millivolt codes and a processor supplies the
 global interrupt enable and a one-cycle vector acknowledge.
*/
// Local design decision: the Avalon-MM interface to the registers.
// Contract
// - raw result high when chosen positive input exceeds chosen negative input
// - comparator has its own interrupt, trigger on rise, fall or toggle
// - without borrowing, pair select picks fixed pin pairs, 101-111 give pin2/pin1
// - borrowing with converter off: channel 0-10 negative, pair select picks positive
// - borrow clear or converter on: negative input always from comparator pins
// - power-off bit switches comparator off at any time, output follows directly
// - bandgap select routes the 1.1V reference to the positive input
// - readable result is synchronised raw result, lagging by 1-2 clocks
// - hardware sets flag when an output event matches trigger mode
// - vector acknowledge clears the flag automatically
// - writing one to flag clears it, writing zero leaves it
// - request only while flag, irq enable and global enable all set
// - irq enable zero disables the request regardless of flag
// - control/status at 0x08, layout fixed, all but result reset zero
// - mode 00 toggle, 01 reserved, 10 falling, 11 rising
module accl_top
    import accl_pkg::*;
#(
    parameter int LEVEL_W = 13
) (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic [7:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic      [31:0]        avs_readdata,
    output logic                    avs_waitrequest,
    input  wire logic [LEVEL_W-1:0] cmp_pin0,
    input  wire logic [LEVEL_W-1:0] cmp_pin1,
    input  wire logic [LEVEL_W-1:0] cmp_pin2,
    input  wire logic [LEVEL_W-1:0] converter_channel_pins [ACCL_NUM_CHAN],
    input  wire logic               converter_enable,
    input  wire logic [5:0]         channel_select_field,
    input  wire logic               global_irq_enable,
    input  wire logic               vector_ack,
    output logic                    comparator_power_off,
    output logic                    raw_result,
    output logic [1:0]              positive_source,
    output logic                    negative_from_channel,
    output logic [3:0]              negative_index,
    output logic                    comparator_irq_req,
    output logic                    irq
);
    localparam logic [LEVEL_W-1:0] BANDGAP_LEVEL = LEVEL_W'(ACCL_BANDGAP_MV);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic                    power_off_q;
    logic                    bandgap_q;
    logic                    flag_q;
    logic                    irq_en_q;
    logic                    borrow_q;
    logic [1:0]              mode_q;
    logic [2:0]              pair_q;
    logic [ACCL_IRQ_BITS-1:0] irq_status_q;
    logic [ACCL_IRQ_BITS-1:0] irq_mask_q;
    logic                    wait_q;
    logic [31:0]             rdata_q;
    logic [ACCL_SYNC_STAGES-1:0] sync_q;
    logic                    prev_q;
    logic                    raw_q;
    logic [1:0]              pos_src_q;
    logic                    neg_chan_q;
    logic [3:0]              neg_idx_q;
    logic                    req_q;
    logic                    irq_q;

    logic                    result;
    logic                    wr_fire;
    logic                    wr_csr;
    logic                    borrow_act;
    logic                    trig_evt;
    logic                    change_evt;
    logic [1:0]              pos_src_d;
    logic                    neg_chan_d;
    logic [3:0]              neg_idx_d;
    logic [LEVEL_W-1:0]      pos_lvl;
    logic [LEVEL_W-1:0]      neg_lvl;
    logic                    raw_d;
    logic [31:0]             rd_mux;

    assign result  = sync_q[ACCL_SYNC_STAGES-1];
    assign wr_fire = avs_write && !wait_q && avs_byteenable[0];
    assign wr_csr  = wr_fire && (avs_address == ACCL_OFS_CTRL_STATUS);

    // ----------------------------------------------------------------
    // input selection
    // ----------------------------------------------------------------
    assign borrow_act = borrow_q && !converter_enable
                        && (channel_select_field <= ACCL_LAST_CHAN);

    always_comb begin
        pos_src_d  = ACCL_POS_PIN2;
        neg_chan_d = 1'b0;
        neg_idx_d  = 4'h1;
        if (borrow_act) begin
            neg_chan_d = 1'b1;
            neg_idx_d  = channel_select_field[3:0];
            if (pair_q == 3'h0) begin
                pos_src_d = ACCL_POS_PIN0;
            end else if (pair_q[2:1] == 2'h1) begin
                pos_src_d = ACCL_POS_PIN1;
            end else begin
                pos_src_d = ACCL_POS_PIN2;
            end
        end else begin
            case (pair_q)
                3'h0: begin
                    pos_src_d = ACCL_POS_PIN0;
                    neg_idx_d = 4'h1;
                end
                3'h1: begin
                    pos_src_d = ACCL_POS_PIN0;
                    neg_idx_d = 4'h2;
                end
                3'h2: begin
                    pos_src_d = ACCL_POS_PIN1;
                    neg_idx_d = 4'h0;
                end
                3'h3: begin
                    pos_src_d = ACCL_POS_PIN1;
                    neg_idx_d = 4'h2;
                end
                3'h4: begin
                    pos_src_d = ACCL_POS_PIN2;
                    neg_idx_d = 4'h0;
                end
                default: begin
                    pos_src_d = ACCL_POS_PIN2;
                    neg_idx_d = 4'h1;
                end
            endcase
        end
        if (bandgap_q) begin
            pos_src_d = ACCL_POS_BANDGAP;
        end
    end

    always_comb begin
        case (pos_src_d)
            ACCL_POS_PIN0: pos_lvl = cmp_pin0;
            ACCL_POS_PIN1: pos_lvl = cmp_pin1;
            ACCL_POS_PIN2: pos_lvl = cmp_pin2;
            default:       pos_lvl = BANDGAP_LEVEL;
        endcase
        if (neg_chan_d) begin
            neg_lvl = converter_channel_pins[neg_idx_d];
        end else begin
            case (neg_idx_d)
                4'h0:    neg_lvl = cmp_pin0;
                4'h1:    neg_lvl = cmp_pin1;
                default: neg_lvl = cmp_pin2;
            endcase
        end
        raw_d = !power_off_q && (pos_lvl > neg_lvl);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pos_src_q  <= ACCL_POS_PIN0;
            neg_chan_q <= ACCL_RST_BIT;
            neg_idx_q  <= 4'h1;
            raw_q      <= ACCL_RST_BIT;
        end else begin
            pos_src_q  <= pos_src_d;
            neg_chan_q <= neg_chan_d;
            neg_idx_q  <= neg_idx_d;
            raw_q      <= raw_d;
        end
    end

    // ----------------------------------------------------------------
    // result synchroniser and trigger detection
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_q <= '0;
            prev_q <= ACCL_RST_BIT;
        end else begin
            sync_q <= {sync_q[ACCL_SYNC_STAGES-2:0], raw_d};
            prev_q <= result;
        end
    end

    assign change_evt = result != prev_q;

    always_comb begin
        case (accl_mode_t'(mode_q))
            ACCL_MODE_TOGGLE: trig_evt = change_evt;
            ACCL_MODE_FALL:   trig_evt = change_evt && !result;
            ACCL_MODE_RISE:   trig_evt = change_evt && result;
            default:          trig_evt = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // event flag and interrupt request
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_q <= ACCL_RST_BIT;
        end else if (trig_evt) begin
            flag_q <= 1'b1;
        end else if (vector_ack) begin
            flag_q <= 1'b0;
        end else if (wr_csr && avs_writedata[ACCL_BIT_FLAG]) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            req_q <= ACCL_RST_BIT;
        end else begin
            req_q <= flag_q && irq_en_q && global_irq_enable;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_status_q <= ACCL_RST_IRQ;
            irq_mask_q   <= ACCL_RST_IRQ;
            irq_q        <= ACCL_RST_BIT;
        end else begin
            irq_status_q <= (irq_status_q
                             & ~((wr_fire && avs_address == ACCL_OFS_IRQ_STATUS)
                                 ? avs_writedata[ACCL_IRQ_BITS-1:0] : ACCL_RST_IRQ))
                            | {change_evt, trig_evt};
            if (wr_fire && avs_address == ACCL_OFS_IRQ_MASK) begin
                irq_mask_q <= avs_writedata[ACCL_IRQ_BITS-1:0];
            end
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            power_off_q <= ACCL_RST_BIT;
            bandgap_q   <= ACCL_RST_BIT;
            irq_en_q    <= ACCL_RST_BIT;
            borrow_q    <= ACCL_RST_BIT;
            mode_q      <= ACCL_RST_MODE;
            pair_q      <= ACCL_RST_PAIR;
        end else if (wr_csr) begin
            power_off_q <= avs_writedata[ACCL_BIT_POWER_OFF];
            bandgap_q   <= avs_writedata[ACCL_BIT_BANDGAP];
            irq_en_q    <= avs_writedata[ACCL_BIT_IRQ_EN];
            borrow_q    <= avs_writedata[ACCL_BIT_BORROW];
            mode_q      <= avs_writedata[ACCL_BIT_MODE_HI:ACCL_BIT_MODE_LO];
        end else if (wr_fire && avs_address == ACCL_OFS_PAIR_SELECT) begin
            pair_q <= avs_writedata[2:0];
        end
    end

    // ----------------------------------------------------------------
    // avalon-mm slave
    // ----------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            ACCL_OFS_CTRL_STATUS: rd_mux[7:0] = {power_off_q, bandgap_q, result, flag_q,
                                                 irq_en_q, borrow_q, mode_q};
            ACCL_OFS_PAIR_SELECT: rd_mux[2:0] = pair_q;
            ACCL_OFS_IRQ_STATUS:  rd_mux[ACCL_IRQ_BITS-1:0] = irq_status_q;
            ACCL_OFS_IRQ_MASK:    rd_mux[ACCL_IRQ_BITS-1:0] = irq_mask_q;
            default:              rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_q  <= ACCL_RST_WAIT;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q <= !(wait_q && (avs_read || avs_write));
            if (wait_q && avs_read) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign avs_readdata          = rdata_q;
    assign avs_waitrequest       = wait_q;
    assign comparator_power_off  = power_off_q;
    assign raw_result            = raw_q;
    assign positive_source       = pos_src_q;
    assign negative_from_channel = neg_chan_q;
    assign negative_index        = neg_idx_q;
    assign comparator_irq_req    = req_q;
    assign irq                   = irq_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_raw_compare: assert property (
        raw_result == $past(!power_off_q && pos_lvl > neg_lvl))
        else $error("raw result does not match input compare");
    chk_pair_fixed: assert property (
        (!borrow_act && !bandgap_q && pair_q == 3'h3)
        |=> (positive_source == ACCL_POS_PIN1 && !negative_from_channel
             && negative_index == 4'h2))
        else $error("pair select 011 not routed to pin1/pin2");
    chk_borrow_neg: assert property (
        (borrow_act && !bandgap_q && pair_q[2])
        |=> (negative_from_channel && positive_source == ACCL_POS_PIN2
             && negative_index == $past(channel_select_field[3:0])))
        else $error("borrowed channel not routed to negative input");
    chk_no_borrow: assert property (
        (!borrow_q || converter_enable) |=> !negative_from_channel)
        else $error("channel used while borrowing inactive");
    chk_power_off: assert property (
        (wr_csr && avs_writedata[ACCL_BIT_POWER_OFF]) |=> comparator_power_off ##1 !raw_result)
        else $error("power off write not effective");
    chk_bandgap_pos: assert property (
        bandgap_q |=> positive_source == ACCL_POS_BANDGAP)
        else $error("bandgap not routed to positive input");
    chk_sync_lag: assert property (
        result == $past(raw_d, 2))
        else $error("synchronised result lag wrong");
    chk_flag_set: assert property (
        (result != prev_q && mode_q == ACCL_MODE_RISE && result) |=> flag_q)
        else $error("rising event did not set flag");
    chk_vector_clear: assert property (
        (vector_ack && !trig_evt) |=> !flag_q)
        else $error("vector acknowledge did not clear flag");
    chk_flag_w1c: assert property (
        (wr_csr && !avs_writedata[ACCL_BIT_FLAG] && !vector_ack && flag_q) |=> flag_q)
        else $error("writing zero cleared flag");
    chk_irq_request: assert property (
        comparator_irq_req == $past(flag_q && irq_en_q && global_irq_enable))
        else $error("irq request not flag and enables");
    chk_irq_disable: assert property (
        !irq_en_q |=> !comparator_irq_req)
        else $error("request while irq enable clear");
    chk_mode_reserved: assert property (
        (mode_q == ACCL_MODE_RESERVED && !flag_q) |=> !flag_q)
        else $error("reserved mode produced trigger");
endmodule // accl_top

//--- tb/accl_analog_model.sv
/*
 analog side of the comparator: pin and converter channel levels.
 assumes the bench sets levels right after a rising clock edge.
*/
module accl_analog_model
    import accl_pkg::*;
#(
    parameter int LEVEL_W = 13
) (
    input  wire logic               clk,
    output logic      [LEVEL_W-1:0] cmp_pin0,
    output logic      [LEVEL_W-1:0] cmp_pin1,
    output logic      [LEVEL_W-1:0] cmp_pin2,
    output logic      [LEVEL_W-1:0] chan [ACCL_NUM_CHAN]
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // levels: 0..2 comparator pins, 3.. converter channels
    // ----------------------------------------------------------------
    logic [LEVEL_W-1:0] lvl_q [ACCL_NUM_CHAN+3];

    initial begin
        for (int i = 0; i < ACCL_NUM_CHAN + 3; i++) begin
            lvl_q[i] = '0;
        end
    end

    task automatic set_level(input int idx, input logic [LEVEL_W-1:0] mv);
        lvl_q[idx] <= mv;
    endtask

    assign cmp_pin0 = lvl_q[0];
    assign cmp_pin1 = lvl_q[1];
    assign cmp_pin2 = lvl_q[2];

    always_comb begin
        for (int i = 0; i < ACCL_NUM_CHAN; i++) begin
            chan[i] = lvl_q[i+3];
        end
    end
endmodule // accl_analog_model

//--- tb/tb.sv
/*
 self-checking bench for the comparator control block.
 assumes the analog model in accl_analog_model and one 100 MHz clock.
*/
module tb
    import accl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic        clk, rst_b, avs_read, avs_write, avs_waitrequest;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic [12:0] cmp_pin0, cmp_pin1, cmp_pin2;
    logic [12:0] chan [ACCL_NUM_CHAN];
    logic        converter_enable, global_irq_enable, vector_ack;
    logic [5:0]  channel_select_field;
    logic        comparator_power_off, raw_result, negative_from_channel;
    logic        comparator_irq_req, irq;
    logic [1:0]  positive_source;
    logic [3:0]  negative_index;
    int          failures, check_count;
    integer      seed;
    logic [31:0] exp_q[$], msk_q[$];
    logic [1:0]  pos_tab [8] = '{0, 0, 1, 1, 2, 2, 2, 2};
    logic [1:0]  bpos_tab [8] = '{0, 2, 1, 1, 2, 2, 2, 2};
    logic [3:0]  neg_tab [8] = '{1, 2, 0, 2, 0, 1, 1, 1};
    logic [3:0]  rise_exp = 4'b1001;
    logic [3:0]  fall_exp = 4'b0101;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    accl_analog_model #(.LEVEL_W(13)) u_ana (.clk(clk), .cmp_pin0(cmp_pin0),
        .cmp_pin1(cmp_pin1), .cmp_pin2(cmp_pin2), .chan(chan));

    accl_top #(.LEVEL_W(13)) i_dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cmp_pin0(cmp_pin0), .cmp_pin1(cmp_pin1),
        .cmp_pin2(cmp_pin2), .converter_channel_pins(chan),
        .converter_enable(converter_enable), .channel_select_field(channel_select_field),
        .global_irq_enable(global_irq_enable), .vector_ack(vector_ack),
        .comparator_power_off(comparator_power_off), .raw_result(raw_result),
        .positive_source(positive_source), .negative_from_channel(negative_from_channel),
        .negative_index(negative_index), .comparator_irq_req(comparator_irq_req),
        .irq(irq));

    // ----------------------------------------------------------------
    // compare, bus and pin tasks
    // ----------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] expv);
        check_count++;
        if (seen !== expv) begin
            failures++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, expv);
        end
    endtask

    task summarize;
        if (failures == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        avs_address    <= a;
        avs_write      <= wr_en;
        avs_read       <= !wr_en;
        avs_writedata  <= d;
        avs_byteenable <= 4'hF;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h000000, d});
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back({24'h000000, e});
        msk_q.push_back({24'hFFFFFF, m});
        bus(1'b0, a, 32'h00000000);
    endtask

    // positive pin0 against negative pin1; low case sits on equality
    task set_cmp(input logic hi);
        u_ana.set_level(1, 13'h0800);
        u_ana.set_level(0, hi ? 13'h0801 + 13'($random(seed) & 1) : 13'h0800);
    endtask

    // ----------------------------------------------------------------
    // read data monitor
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        logic [31:0] m;
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            m = msk_q.pop_front();
            check(avs_readdata & m, exp_q.pop_front() & m);
        end
    end

    initial begin
        #200us;
        failures++;
        summarize;
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 32'he9a0;
        failures = 0;
        check_count = 0;
        rst_b = 1'b0;
        {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
        {converter_enable, channel_select_field, global_irq_enable, vector_ack} = '0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        u_ana.set_level(2, 13'($random(seed)));
        @(posedge clk);
        rd(ACCL_OFS_CTRL_STATUS, 8'h00, 8'hDF);
        rd(ACCL_OFS_PAIR_SELECT, 8'h00, 8'hFF);
        rd(ACCL_OFS_IRQ_STATUS, 8'h00, 8'hFF);
        rd(ACCL_OFS_IRQ_MASK, 8'h00, 8'hFF);
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00, 8'hFF);
        rd(ACCL_OFS_CTRL_STATUS, 8'h00, 8'hDF);
        for (int p = 0; p < 2; p++) begin
            converter_enable <= p[0];
            wr(ACCL_OFS_CTRL_STATUS, p[0] ? 8'h04 : 8'h00);
            for (int s = 0; s < 8; s++) begin
                channel_select_field <= 6'($random(seed));
                wr(ACCL_OFS_PAIR_SELECT, 8'(s));
                tick(1);
                check(positive_source, pos_tab[s]);
                check({negative_from_channel, negative_index}, {1'b0, neg_tab[s]});
            end
        end
        converter_enable <= 1'b0;
        for (int c = 0; c <= 10; c++) begin
            int s;
            s = $random(seed) & 7;
            channel_select_field <= 6'(c);
            u_ana.set_level(c + 3, 13'($random(seed)));
            wr(ACCL_OFS_PAIR_SELECT, 8'(s));
            tick(1);
            check(positive_source, bpos_tab[s]);
            check({negative_from_channel, negative_index}, {1'b1, 4'(c)});
        end
        wr(ACCL_OFS_CTRL_STATUS, 8'h40);
        tick(1);
        check(positive_source, ACCL_POS_BANDGAP);
        wr(ACCL_OFS_PAIR_SELECT, 8'h00);
        // bandgap off and result settled low before the mode sweep
        wr(ACCL_OFS_CTRL_STATUS, 8'h00);
        tick(4);
        for (int m = 0; m < 4; m++) begin
            wr(ACCL_OFS_CTRL_STATUS, {6'b000100, 2'(m)});
            set_cmp(1'b1);
            rd(ACCL_OFS_CTRL_STATUS, 8'h00, 8'h20);
            rd(ACCL_OFS_CTRL_STATUS, 8'h20, 8'h20);
            tick(4);
            check(raw_result, 1'b1);
            wr(ACCL_OFS_CTRL_STATUS, {6'b000000, 2'(m)});
            rd(ACCL_OFS_CTRL_STATUS, {3'b001, rise_exp[m], 2'b00, 2'(m)}, 8'hFF);
            wr(ACCL_OFS_CTRL_STATUS, {6'b000100, 2'(m)});
            set_cmp(1'b0);
            tick(6);
            check(raw_result, 1'b0);
            rd(ACCL_OFS_CTRL_STATUS, {3'b000, fall_exp[m], 2'b00, 2'(m)}, 8'hFF);
        end
        wr(ACCL_OFS_CTRL_STATUS, 8'h1B);
        global_irq_enable <= 1'b1;
        set_cmp(1'b1);
        tick(6);
        check(comparator_irq_req, 1'b1);
        global_irq_enable <= 1'b0;
        tick(2);
        check(comparator_irq_req, 1'b0);
        global_irq_enable <= 1'b1;
        tick(2);
        check(comparator_irq_req, 1'b1);
        wr(ACCL_OFS_CTRL_STATUS, 8'h03);
        tick(2);
        check(comparator_irq_req, 1'b0);
        rd(ACCL_OFS_CTRL_STATUS, 8'h33, 8'hFF);
        vector_ack <= 1'b1;
        @(posedge clk);
        vector_ack <= 1'b0;
        tick(2);
        rd(ACCL_OFS_CTRL_STATUS, 8'h23, 8'hFF);
        wr(ACCL_OFS_IRQ_STATUS, 8'h03);
        rd(ACCL_OFS_IRQ_STATUS, 8'h00, 8'hFF);
        wr(ACCL_OFS_IRQ_MASK, 8'h02);
        set_cmp(1'b0);
        tick(6);
        rd(ACCL_OFS_IRQ_STATUS, 8'h02, 8'hFF);
        check(irq, 1'b1);
        wr(ACCL_OFS_IRQ_MASK, 8'h00);
        tick(2);
        check(irq, 1'b0);
        wr(ACCL_OFS_IRQ_MASK, 8'h03);
        set_cmp(1'b1);
        tick(6);
        rd(ACCL_OFS_IRQ_STATUS, 8'h03, 8'hFF);
        wr(ACCL_OFS_IRQ_STATUS, 8'h03);
        tick(2);
        check(irq, 1'b0);
        // irq enable already clear before the power bit moves
        wr(ACCL_OFS_CTRL_STATUS, 8'h83);
        tick(1);
        check(comparator_power_off, 1'b1);
        check(raw_result, 1'b0);
        wr(ACCL_OFS_CTRL_STATUS, 8'h03);
        tick(1);
        check(comparator_power_off, 1'b0);
        tick(2);
        summarize;
    end
endmodule // tb
